// >>> rtl/ctb_transmit_buffers.sv
/*
 * Three CAN transmit buffers with an Avalon-MM slave, priority arbiter,
 * status tracking and transmit error counter.
 * Assumes a protocol engine on the same clock that takes a frame while
 * tx_frame_valid is high and answers with one-cycle outcome pulses.
 */
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module ctb_transmit_buffers (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output ctb_pkg::ctb_frame_t tx_frame,
  output logic tx_frame_valid,
  output logic tx_abort,
  input wire ctb_pkg::ctb_outcome_t eng_outcome,
  input wire logic can_rx,
  input wire logic bit_sample,
  output logic bus_off
);

  // ==========================================================
  // State
  ctb_pkg::ctb_state_t st_q; // Registered state
  ctb_pkg::ctb_state_t st_d; // Next state

  logic [6:0] idx;        // Word index
  logic [3:0] sub;        // Register within a buffer
  logic hit;              // Address reaches a transmit buffer
  logic [1:0] bsel;       // Buffer addressed
  logic wr_go;            // Write takes effect this edge
  logic [7:0] rd_byte;    // Read value
  logic best_ok;          // Some buffer is pending
  logic [1:0] best;       // Winning buffer
  logic [1:0] best_pri;   // Winning priority
  logic any_out;          // Engine reports an outcome

  // ==========================================================
  // Helpers
  // Builds the frame handed to the engine
  function automatic ctb_pkg::ctb_frame_t build(input ctb_pkg::ctb_buf_t b);
    ctb_pkg::ctb_frame_t f;
    f.ide = b.ide;
    f.rtr = b.rtr; // RULE15
    if (b.ide) begin
      f.id = {b.sidh, b.sid_lo, b.eid_hi, b.eidh, b.eidl}; // RULE10
    end else begin
      f.id = {18'h00000, b.sidh, b.sid_lo}; // RULE11
    end
    f.dlc = b.dlc;
    if (b.rtr) begin
      f.nbytes = 4'h0;
    end else if (b.dlc > ctb_pkg::MAX_BYTES) begin
      f.nbytes = ctb_pkg::MAX_BYTES; // RULE16
    end else begin
      f.nbytes = b.dlc;
    end
    f.data = b.data; // RULE14
    return f;
  endfunction

  // Read view of one buffer register
  function automatic logic [7:0] rd_reg(input ctb_pkg::ctb_buf_t b, input logic [3:0] s);
    logic [7:0] v;
    v = 8'h00; // RULE21
    case (s)
      ctb_pkg::SUB_CTL: begin
        v[ctb_pkg::CTL_DONE_BIT] = b.done;
        v[ctb_pkg::CTL_ABT_BIT] = b.aborted;
        v[ctb_pkg::CTL_LARB_BIT] = b.lost_arb;
        v[ctb_pkg::CTL_BERR_BIT] = b.bus_err;
        v[ctb_pkg::CTL_REQ_BIT] = b.req;
        v[ctb_pkg::CTL_PRI_LSB +: 2] = b.prio;
      end
      ctb_pkg::SUB_SIDH: v = b.sidh; // RULE12
      ctb_pkg::SUB_SIDL: begin
        v[ctb_pkg::SIDL_SID_LSB +: 3] = b.sid_lo; // RULE13
        v[ctb_pkg::SIDL_IDE_BIT] = b.ide;
        v[ctb_pkg::SIDL_EID_LSB +: 2] = b.eid_hi;
      end
      ctb_pkg::SUB_EIDH: v = b.eidh;
      ctb_pkg::SUB_EIDL: v = b.eidl;
      ctb_pkg::SUB_DLC: begin
        v[ctb_pkg::DLC_RTR_BIT] = b.rtr;
        v[ctb_pkg::DLC_CODE_LSB +: 4] = b.dlc;
      end
      default: begin
        if (s[3]) begin
          v = b.data[s[2:0]]; // RULE14
        end
      end
    endcase
    return v;
  endfunction

  // ==========================================================
  // Address decode
  assign idx = avs_address[8:2];
  assign sub = idx[3:0];
  // Window region reaches buffer zero only when selected
  assign hit = (idx[6:4] < ctb_pkg::IDX_WIN[6:4]) ||
               (idx[6:4] == ctb_pkg::IDX_WIN[6:4] && st_q.window_select == ctb_pkg::WIN_TX_BUFFER_ZERO); // RULE20
  assign bsel = (idx[6:4] == ctb_pkg::IDX_WIN[6:4]) ? 2'h0 : idx[5:4];
  assign wr_go = avs_write && !st_q.wait_q && avs_byteenable[0];
  assign any_out = eng_outcome.done || eng_outcome.lost_arb || eng_outcome.bus_error;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit) begin
      rd_byte = rd_reg(st_q.bufs[bsel], sub);
    end else if (idx == ctb_pkg::IDX_TEC) begin
      rd_byte = st_q.tec;
    end else if (idx == ctb_pkg::IDX_MODCTL) begin
      rd_byte[ctb_pkg::WIN_LSB +: 3] = st_q.window_select;
    end else if (idx == ctb_pkg::IDX_STATUS) begin
      rd_byte[ctb_pkg::STAT_BOFF_BIT] = st_q.bus_off;
      rd_byte[ctb_pkg::STAT_BUSY_BIT] = st_q.frame_valid;
      rd_byte[ctb_pkg::STAT_ACT_LSB +: 2] = st_q.act;
    end
  end

  // Arbiter: highest priority, higher buffer number wins a tie
  always_comb begin
    best_ok = 1'b0;
    best = 2'h0;
    best_pri = 2'h0;
    for (int i = 0; i < ctb_pkg::NUM_BUF; i++) begin
      if (st_q.bufs[i].req && !st_q.bufs[i].abort_pend &&
          (!best_ok || st_q.bufs[i].prio >= best_pri)) begin // RULE9
        best_ok = 1'b1;
        best = 2'(i);
        best_pri = st_q.bufs[i].prio;
      end
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    // Pin synchroniser
    st_d.sync1 = can_rx;
    st_d.sync2 = st_q.sync1;
    // Bus answer one cycle after the request
    st_d.wait_q = !((avs_read || avs_write) && st_q.wait_q);
    if (avs_read && st_q.wait_q) begin
      st_d.rdata = {24'h000000, rd_byte};
    end
    // Module control write
    if (wr_go && idx == ctb_pkg::IDX_MODCTL) begin
      st_d.window_select = avs_writedata[ctb_pkg::WIN_LSB +: 3];
    end
    // Software writes to buffers
    for (int i = 0; i < ctb_pkg::NUM_BUF; i++) begin
      if (wr_go && hit && bsel == 2'(i)) begin
        if (sub == ctb_pkg::SUB_CTL) begin
          // Done flag clears on a written zero
          if (!avs_writedata[ctb_pkg::CTL_DONE_BIT]) begin
            st_d.bufs[i].done = 1'b0;
          end
          if (!st_q.bufs[i].req) begin
            st_d.bufs[i].prio = avs_writedata[ctb_pkg::CTL_PRI_LSB +: 2];
            if (avs_writedata[ctb_pkg::CTL_REQ_BIT]) begin
              st_d.bufs[i].req = 1'b1; // RULE5
              st_d.bufs[i].aborted = 1'b0;
              st_d.bufs[i].lost_arb = 1'b0;
              st_d.bufs[i].bus_err = 1'b0;
            end
          end else if (!avs_writedata[ctb_pkg::CTL_REQ_BIT] && !st_q.bufs[i].abort_pend) begin
            if (st_q.frame_valid && st_q.act == 2'(i)) begin
              st_d.bufs[i].abort_pend = 1'b1; // RULE8
            end else begin
              st_d.bufs[i].req = 1'b0; // RULE8
              st_d.bufs[i].aborted = 1'b1; // RULE2
            end
          end
        end else if (!st_q.bufs[i].req) begin // RULE7
          case (sub)
            ctb_pkg::SUB_SIDH: st_d.bufs[i].sidh = avs_writedata[7:0]; // RULE12
            ctb_pkg::SUB_SIDL: begin
              st_d.bufs[i].sid_lo = avs_writedata[ctb_pkg::SIDL_SID_LSB +: 3]; // RULE13
              st_d.bufs[i].ide = avs_writedata[ctb_pkg::SIDL_IDE_BIT];
              st_d.bufs[i].eid_hi = avs_writedata[ctb_pkg::SIDL_EID_LSB +: 2];
            end
            ctb_pkg::SUB_EIDH: st_d.bufs[i].eidh = avs_writedata[7:0];
            ctb_pkg::SUB_EIDL: st_d.bufs[i].eidl = avs_writedata[7:0];
            ctb_pkg::SUB_DLC: begin
              st_d.bufs[i].rtr = avs_writedata[ctb_pkg::DLC_RTR_BIT]; // RULE15
              st_d.bufs[i].dlc = avs_writedata[ctb_pkg::DLC_CODE_LSB +: 4];
            end
            default: begin
              if (sub[3]) begin
                st_d.bufs[i].data[sub[2:0]] = avs_writedata[7:0]; // RULE14
              end
            end
          endcase
        end
      end
    end
    // Engine outcome; hardware sets win over software clears
    if (st_q.frame_valid && any_out) begin
      st_d.frame_valid = 1'b0;
      if (eng_outcome.done) begin
        st_d.bufs[st_q.act].done = 1'b1; // RULE1
        st_d.bufs[st_q.act].req = 1'b0; // RULE6
        st_d.bufs[st_q.act].abort_pend = 1'b0;
        if (st_q.tec != 8'h00) begin
          st_d.tec = st_q.tec - ctb_pkg::TEC_OK_DEC; // RULE22
        end
      end else if (st_d.bufs[st_q.act].abort_pend) begin
        // An abort raised in this same cycle is honoured, so it never sticks
        st_d.bufs[st_q.act].aborted = 1'b1; // RULE2
        st_d.bufs[st_q.act].req = 1'b0;
        st_d.bufs[st_q.act].abort_pend = 1'b0;
      end
      if (eng_outcome.lost_arb) begin
        st_d.bufs[st_q.act].lost_arb = 1'b1; // RULE3
      end
      if (eng_outcome.bus_error) begin
        st_d.bufs[st_q.act].bus_err = 1'b1; // RULE4
        if (st_q.tec > ctb_pkg::TEC_NO_OVF_MAX) begin
          st_d.tec = ctb_pkg::TEC_FULL; // RULE17
          st_d.bus_off = 1'b1;
        end else begin
          st_d.tec = st_q.tec + ctb_pkg::TEC_ERR_INC; // RULE22
        end
      end
    end else if (!st_q.frame_valid && !st_q.bus_off && best_ok &&
                 st_d.bufs[best].req && !st_d.bufs[best].abort_pend) begin
      // Start the winning buffer
      st_d.frame_valid = 1'b1; // RULE9
      st_d.act = best;
      st_d.frame = build(st_q.bufs[best]);
    end
    // Bus-off recovery on runs of recessive bits
    if (st_q.bus_off && bit_sample) begin
      if (!st_q.sync2) begin
        st_d.run_cnt = 4'h0;
      end else if (st_q.run_cnt == ctb_pkg::RUN_LAST) begin
        st_d.run_cnt = 4'h0;
        if (st_q.recov_cnt == ctb_pkg::RECOV_LAST) begin
          st_d.recov_cnt = 8'h00;
          st_d.tec = 8'h00; // RULE18
          st_d.bus_off = 1'b0;
        end else begin
          st_d.recov_cnt = st_q.recov_cnt + 8'h01;
        end
      end else begin
        st_d.run_cnt = st_q.run_cnt + 4'h1;
      end
    end
    st_d.abort_out = st_d.frame_valid && st_d.bufs[st_d.act].abort_pend;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ctb_pkg::STATE_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = st_q.wait_q;
  assign tx_frame = st_q.frame;
  assign tx_frame_valid = st_q.frame_valid;
  assign tx_abort = st_q.abort_out;
  assign bus_off = st_q.bus_off;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic ctl_wr; // Control write reaching a buffer
  assign ctl_wr = clk_en && wr_go && hit && sub == ctb_pkg::SUB_CTL;

  property p_wait_one;
    (clk_en && !avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low longer than one cycle");

  property p_done;
    (clk_en && tx_frame_valid && eng_outcome.done) |=> st_q.bufs[$past(st_q.act)].done;
  endproperty
  a_done: assert property (p_done) else $error("done flag not set"); // RULE1

  property p_abort_idle;
    (ctl_wr && st_q.bufs[bsel].req && !avs_writedata[ctb_pkg::CTL_REQ_BIT] &&
     !st_q.bufs[bsel].abort_pend && !(st_q.frame_valid && st_q.act == bsel))
    |=> st_q.bufs[$past(bsel)].aborted && !st_q.bufs[$past(bsel)].req;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort not recorded"); // RULE2

  property p_lost;
    (clk_en && tx_frame_valid && eng_outcome.lost_arb) |=> st_q.bufs[$past(st_q.act)].lost_arb;
  endproperty
  a_lost: assert property (p_lost) else $error("lost arbitration not recorded"); // RULE3

  property p_berr;
    (clk_en && tx_frame_valid && eng_outcome.bus_error) |=> st_q.bufs[$past(st_q.act)].bus_err;
  endproperty
  a_berr: assert property (p_berr) else $error("bus error not recorded"); // RULE4

  property p_req_clears;
    (ctl_wr && !st_q.bufs[bsel].req && avs_writedata[ctb_pkg::CTL_REQ_BIT]) |=>
      st_q.bufs[$past(bsel)].req && !st_q.bufs[$past(bsel)].aborted &&
      !st_q.bufs[$past(bsel)].lost_arb && !st_q.bufs[$past(bsel)].bus_err;
  endproperty
  a_req_clears: assert property (p_req_clears) else $error("request did not clear status"); // RULE5

  property p_req_self_clear;
    (clk_en && tx_frame_valid && eng_outcome.done) |=>
      !st_q.bufs[$past(st_q.act)].req && !tx_frame_valid;
  endproperty
  a_req_self_clear: assert property (p_req_self_clear) else $error("request stuck"); // RULE6

  property p_locked;
    (clk_en && wr_go && hit && sub[3] && st_q.bufs[bsel].req) |=>
      st_q.bufs[$past(bsel)].data == $past(st_q.bufs[bsel].data);
  endproperty
  a_locked: assert property (p_locked) else $error("data changed while requested"); // RULE7

  property p_prio;
    $rose(tx_frame_valid) |->
      (!$past(st_q.bufs[0].req) || $past(st_q.bufs[0].prio) <= st_q.bufs[st_q.act].prio) &&
      (!$past(st_q.bufs[1].req) || $past(st_q.bufs[1].prio) <= st_q.bufs[st_q.act].prio) &&
      (!$past(st_q.bufs[2].req) || $past(st_q.bufs[2].prio) <= st_q.bufs[st_q.act].prio);
  endproperty
  a_prio: assert property (p_prio) else $error("lower priority buffer started"); // RULE9

  property p_ext_id;
    (tx_frame_valid && tx_frame.ide) |->
      tx_frame.id[28:ctb_pkg::ID_STD_LSB] ==
      {st_q.bufs[st_q.act].sidh, st_q.bufs[st_q.act].sid_lo};
  endproperty
  a_ext_id: assert property (p_ext_id) else $error("extended id misplaced"); // RULE10

  property p_overflow;
    (clk_en && tx_frame_valid && eng_outcome.bus_error && st_q.tec > ctb_pkg::TEC_NO_OVF_MAX)
    |=> bus_off;
  endproperty
  a_overflow: assert property (p_overflow) else $error("no bus-off on overflow"); // RULE17

  property p_recover;
    (clk_en && bus_off && bit_sample && st_q.sync2 && st_q.run_cnt == ctb_pkg::RUN_LAST &&
     st_q.recov_cnt == ctb_pkg::RECOV_LAST) |=> st_q.tec == 8'h00 && !bus_off;
  endproperty
  a_recover: assert property (p_recover) else $error("counter not cleared after recovery"); // RULE18

  property p_upper_zero;
    avs_readdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unimplemented bits read nonzero"); // RULE21

  cover property (tx_frame_valid && eng_outcome.done);
  cover property (tx_frame_valid && eng_outcome.lost_arb);
  cover property (tx_abort ##1 !tx_frame_valid);
  cover property ($fell(bus_off));

endmodule

// >>> rtl/ctb_pkg.sv
/*
 * Constants, field layouts and carrier types for the CAN transmit buffer block.
 * Assumes a 125 MHz module clock and an external protocol engine that serialises frames.
 */
// Operation
// RULE1: Finished buffer sets done flag, software clears
// RULE2: Aborted message sets aborted status until rerequest
// RULE3: Lost arbitration sets lost-arbitration status
// RULE4: Bus error during send sets bus-error status
// RULE5: Setting request clears aborted, lost, error status
// RULE6: Request clears itself after successful send
// RULE7: Identifier, length, data read-only while requested
// RULE8: Clearing pending request asks for an abort
// RULE9: Two-bit priority orders pending buffers, highest first
// RULE10: Extended enable sends 29-bit identifier, standard on top
// RULE11: Standard mode sends 11 bits, ignores extension
// RULE12: Identifier high holds standard bits ten to three
// RULE13: Identifier low holds bits two-zero, seventeen-sixteen
// RULE14: Each buffer has eight data bytes sent in order
// RULE15: Length bit six selects remote frame
// RULE16: Length code 0-8 bytes, 9-15 reserved
// RULE17: Read-only error counter; overflow enters bus-off
// RULE18: 128 runs of 11 recessive bits clear counter
// RULE19: Software selects normal or loopback mode first; no mode select is implemented, buffers start without one
// RULE20: Window select maps buffer zero onto receive window
// RULE21: Unimplemented bits read back as zero
// RULE22: Counter follows transmitter fault-confinement rules
package ctb_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_BUF = 3;            // Dedicated transmit buffers
  localparam int ID_STD_LSB = 18;        // Standard bits sit on top of 29-bit id

  // ==========================================================
  // Register word indices (byte address = index * 4)
  localparam logic [6:0] IDX_WIN = 7'h30;     // Receive buffer zero window
  localparam logic [6:0] IDX_TEC = 7'h40;     // Transmit error counter
  localparam logic [6:0] IDX_MODCTL = 7'h41;  // Module control (window select)
  localparam logic [6:0] IDX_STATUS = 7'h42;  // Engine status
  localparam logic [3:0] SUB_CTL = 4'h0;
  localparam logic [3:0] SUB_SIDH = 4'h1;
  localparam logic [3:0] SUB_SIDL = 4'h2;
  localparam logic [3:0] SUB_EIDH = 4'h3;
  localparam logic [3:0] SUB_EIDL = 4'h4;
  localparam logic [3:0] SUB_DLC = 4'h5;

  // ==========================================================
  // Field positions
  localparam int CTL_DONE_BIT = 7;
  localparam int CTL_ABT_BIT = 6;
  localparam int CTL_LARB_BIT = 5;
  localparam int CTL_BERR_BIT = 4;
  localparam int CTL_REQ_BIT = 3;
  localparam int CTL_PRI_LSB = 0;
  localparam int SIDL_SID_LSB = 5;
  localparam int SIDL_IDE_BIT = 3;
  localparam int SIDL_EID_LSB = 0;
  localparam int DLC_RTR_BIT = 6;
  localparam int DLC_CODE_LSB = 0;
  localparam int WIN_LSB = 1;
  localparam int STAT_BOFF_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_ACT_LSB = 2;
  localparam logic [2:0] WIN_TX_BUFFER_ZERO = 3'h4;    // Window code for buffer zero

  // ==========================================================
  // Counts
  localparam logic [3:0] MAX_BYTES = 4'h8;
  localparam logic [7:0] TEC_ERR_INC = 8'h08;
  localparam logic [7:0] TEC_OK_DEC = 8'h01;
  localparam logic [7:0] TEC_NO_OVF_MAX = 8'hf7;
  localparam logic [7:0] TEC_FULL = 8'hff;
  localparam logic [3:0] RUN_LAST = 4'ha;    // Eleventh recessive bit
  localparam logic [7:0] RECOV_LAST = 8'h7f; // 128th run

  // ==========================================================
  // Types
  typedef struct packed {
    logic done;
    logic aborted;
    logic lost_arb;
    logic bus_err;
    logic req;
    logic abort_pend;
    logic [1:0] prio;
    logic [7:0] sidh;
    logic [2:0] sid_lo;
    logic ide;
    logic [1:0] eid_hi;
    logic [7:0] eidh;
    logic [7:0] eidl;
    logic rtr;
    logic [3:0] dlc;
    logic [7:0][7:0] data;
  } ctb_buf_t;

  typedef struct packed {
    logic ide;
    logic rtr;
    logic [28:0] id;
    logic [3:0] dlc;
    logic [3:0] nbytes;
    logic [7:0][7:0] data;
  } ctb_frame_t;

  typedef struct packed {
    logic done;
    logic lost_arb;
    logic bus_error;
  } ctb_outcome_t;

  typedef struct packed {
    ctb_buf_t [NUM_BUF-1:0] bufs;
    logic [7:0] tec;
    logic bus_off;
    logic [2:0] window_select;
    logic [3:0] run_cnt;
    logic [7:0] recov_cnt;
    logic sync1;
    logic sync2;
    logic wait_q;
    logic [31:0] rdata;
    logic frame_valid;
    logic [1:0] act;
    logic abort_out;
    ctb_frame_t frame;
  } ctb_state_t;

  localparam ctb_state_t STATE_RESET = '{wait_q: 1'b1, default: '0};

endpackage

// >>> bench/ctb_engine_model.sv
/*
 * Behavioural protocol engine that stands for the CAN bus beyond the buffers.
 * Assumes the frame is held while tx_frame_valid is high and that one
 * outcome pulse of one cycle ends each attempt.
 */
`timescale 1ns/1ps
module ctb_engine_model #(
  parameter int DELAY = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tx_frame_valid,
  input wire ctb_pkg::ctb_frame_t tx_frame,
  input wire logic [1:0] kind,
  input wire logic [7:0] n_fail,
  output ctb_pkg::ctb_outcome_t eng_outcome,
  output ctb_pkg::ctb_frame_t last_frame,
  output ctb_pkg::ctb_frame_t prev_frame
);
  // ==========================================================
  // State
  logic answered_q; // Outcome given, waiting for valid to fall
  logic [7:0] cnt_q; // Cycles spent in the current attempt
  logic [7:0] fails_q; // Failed attempts since the last success

  // Kind 0 succeeds, 1 loses arbitration, 2 meets a bus error, 3 stalls
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      answered_q <= 1'b0;
      cnt_q <= 8'h00;
      fails_q <= 8'h00;
      eng_outcome <= '0;
      last_frame <= '0;
      prev_frame <= '0;
    end else begin
      eng_outcome <= '0;
      if (!tx_frame_valid) begin
        // Idle between attempts
        answered_q <= 1'b0;
        cnt_q <= 8'h00;
      end else if (!answered_q) begin
        if (cnt_q == 8'h00) begin
          // Record the frame as it starts
          last_frame <= tx_frame;
          prev_frame <= last_frame;
        end
        if (cnt_q < 8'(DELAY)) begin
          cnt_q <= cnt_q + 8'h01;
        end else if (kind != 2'h3) begin
          answered_q <= 1'b1;
          if (kind != 2'h0 && fails_q < n_fail) begin
            // Failed attempt; the buffer retries
            fails_q <= fails_q + 8'h01;
            eng_outcome.lost_arb <= (kind == 2'h1);
            eng_outcome.bus_error <= (kind == 2'h2);
          end else begin
            fails_q <= 8'h00;
            eng_outcome.done <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// >>> bench/can_transmit_buffers_test.sv
/*
 * Self-checking bench for the CAN transmit buffers, driven over Avalon-MM.
 * Assumes the engine model above and a one-cycle answer on the register bus.
 */
`timescale 1ns/1ps
module can_transmit_buffers_test;
  // ==========================================================
  // Signals
  logic clock;
  logic arst_n;
  logic avs_read;
  logic avs_write;
  logic avs_waitrequest;
  logic can_rx;
  logic bit_sample;
  logic bus_off;
  logic tx_frame_valid;
  logic tx_abort;
  logic [8:0] avs_address;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] rv; // Last read value
  logic [1:0] kind; // Engine behaviour
  logic [7:0] n_fail; // Failed attempts before success
  ctb_pkg::ctb_frame_t tx_frame;
  ctb_pkg::ctb_frame_t last_frame;
  ctb_pkg::ctb_frame_t prev_frame;
  ctb_pkg::ctb_outcome_t eng_outcome;
  int num_errors = 0;
  int n_tests = 0;

  ctb_transmit_buffers dut_u (.clock(clock), .arst_n(arst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_frame(tx_frame), .tx_frame_valid(tx_frame_valid),
    .tx_abort(tx_abort), .eng_outcome(eng_outcome), .can_rx(can_rx), .bit_sample(bit_sample),
    .bus_off(bus_off));

  ctb_engine_model eng_u (.clock(clock), .arst_n(arst_n), .tx_frame_valid(tx_frame_valid),
    .tx_frame(tx_frame), .kind(kind), .n_fail(n_fail), .eng_outcome(eng_outcome),
    .last_frame(last_frame), .prev_frame(prev_frame));

  // ==========================================================
  // Tasks
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task xfer(input logic [8:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    forever begin
      @(posedge clock);
      n++;
      if (avs_waitrequest === 1'b0) break;
      if (n > 50) begin
        check("bus answer", 32'h0, 32'h1);
        break;
      end
    end
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task wr(input logic [8:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rc(input logic [8:0] a, input logic [31:0] exp, input string name);
    xfer(a, 1'b0, 8'h00);
    check(name, rv, exp);
  endtask

  // Poll a control register until its request bit falls
  task wait_req(input logic [8:0] a);
    for (int i = 0; i < 200; i++) begin
      xfer(a, 1'b0, 8'h00);
      if (rv[3] === 1'b0) break;
    end
    check("request cleared", 32'(rv[3]), 32'h0);
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    #400000;
    $display("watchdog expired");
    num_errors++;
    results();
  end

  // ==========================================================
  // Test sequence
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 9'h000;
    avs_writedata = 32'h0;
    can_rx = 1'b1;
    bit_sample = 1'b0;
    kind = 2'h0;
    n_fail = 8'h00;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    rc(9'h000, 32'h00, "ctl reset");
    rc(9'h100, 32'h00, "tec reset");
    wr(9'h000, 8'hf7);
    rc(9'h000, 32'h03, "ctl fixed bits");
    wr(9'h008, 8'hff);
    rc(9'h008, 32'heb, "sidl fixed bits");
    wr(9'h014, 8'hff);
    rc(9'h014, 32'h4f, "dlc fixed bits");
    // Standard frame with full data field, extension bits set but unused
    wr(9'h004, 8'h24);
    wr(9'h008, 8'h60);
    wr(9'h00c, 8'hff);
    wr(9'h010, 8'hff);
    wr(9'h014, 8'h08);
    for (int m = 0; m < 8; m++) wr(9'(32 + 4 * m), 8'(16 + m));
    wr(9'h000, 8'h08);
    wait_req(9'h000);
    rc(9'h000, 32'h80, "done set");
    check("std id", 32'(last_frame.id), 32'h123);
    check("std ide", 32'(last_frame.ide), 32'h0);
    check("bytes", 32'(last_frame.nbytes), 32'h8);
    for (int m = 0; m < 8; m++) check("data", 32'(last_frame.data[m]), 32'(16 + m));
    wr(9'h000, 8'h00);
    rc(9'h000, 32'h00, "done cleared");
    // Extended remote frame
    wr(9'h044, 8'haa);
    wr(9'h048, 8'hab);
    wr(9'h04c, 8'h5a);
    wr(9'h050, 8'hc3);
    wr(9'h054, 8'h43);
    wr(9'h040, 8'h08);
    wait_req(9'h040);
    check("ext id", 32'(last_frame.id), 32'h15575ac3);
    check("ext ide", 32'(last_frame.ide), 32'h1);
    check("remote", 32'(last_frame.rtr), 32'h1);
    check("remote code", 32'(last_frame.dlc), 32'h3);
    // Lost arbitration, then bus error; each new request clears old status
    wr(9'h084, 8'h7f);
    kind <= 2'h1;
    n_fail <= 8'h01;
    wr(9'h080, 8'h08);
    wait_req(9'h080);
    rc(9'h080, 32'ha0, "lost arb");
    kind <= 2'h2;
    wr(9'h080, 8'h08);
    wait_req(9'h080);
    rc(9'h080, 32'h90, "bus error");
    rc(9'h100, 32'h07, "tec count");
    // Held transfer: locked registers and priority order
    kind <= 2'h3;
    wr(9'h000, 8'h08);
    wr(9'h004, 8'h11);
    rc(9'h004, 32'h24, "locked sidh");
    wr(9'h020, 8'h55);
    rc(9'h020, 32'h10, "locked data");
    wr(9'h040, 8'h0b);
    wr(9'h080, 8'h08);
    kind <= 2'h0;
    wait_req(9'h080);
    check("first by priority", 32'(prev_frame.id), 32'h15575ac3);
    check("second by priority", 32'(last_frame.id), 32'h3f8);
    // Abort of a pending buffer
    kind <= 2'h3;
    wr(9'h000, 8'h08);
    wr(9'h040, 8'h08);
    wr(9'h040, 8'h00);
    rc(9'h040, 32'h40, "aborted");
    // Abort of the buffer in flight, ended by lost arbitration
    wr(9'h000, 8'h00);
    @(posedge clock);
    check("abort pending", 32'(tx_abort), 32'h1);
    kind <= 2'h1;
    wait_req(9'h000);
    rc(9'h000, 32'h60, "abort in flight");
    // Window onto buffer zero, and an unmapped place
    rc(9'h0c4, 32'h00, "window closed");
    wr(9'h104, 8'h08);
    rc(9'h0c4, 32'h24, "window open");
    rc(9'h1fc, 32'h00, "unmapped");
    // Repeated bus errors drive the counter into bus-off
    kind <= 2'h2;
    n_fail <= 8'hff;
    wr(9'h000, 8'h08);
    for (int i = 0; i < 5000 && bus_off !== 1'b1; i++) @(posedge clock);
    check("bus off", 32'(bus_off), 32'h1);
    rc(9'h100, 32'hff, "tec full");
    // Recovery after 128 runs of 11 recessive bits
    kind <= 2'h0;
    repeat (1407) begin
      @(posedge clock);
      bit_sample <= 1'b1;
      @(posedge clock);
      bit_sample <= 1'b0;
    end
    repeat (4) @(posedge clock);
    check("still off", 32'(bus_off), 32'h1);
    bit_sample <= 1'b1;
    @(posedge clock);
    bit_sample <= 1'b0;
    repeat (4) @(posedge clock);
    check("recovered", 32'(bus_off), 32'h0);
    rc(9'h100, 32'h00, "tec cleared");
    results();
  end
endmodule
